// ==== hdl/igp_host_ctrl.sv ====
/*
  Host-side controller for the three-phase gate driver: drives per-phase
  commands, watches the wired fault line and may pull it low to shut down.
  Assumes the fault line has an external pull-up and the pins are async.
*/
`timescale 1ns/100ps
// What this block does
// - drive all commands low when line falls
// - wait two seconds before restarting motor
// - hold shutdown low three microseconds, then high through the restart wait
// - host inserts its own dead time
module igp_host_ctrl
  import igp_pkg::*;
#(
  parameter longint RESTART_CYC = RESTART_WAIT_CYC,
  parameter int DEAD_CYC = DEAD_TIME_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [2:0] i_want_high,
  input wire logic [2:0] i_want_low,
  input wire logic i_run,
  input wire logic i_shutdown_req,
  input wire logic i_fault_line_in,
  output logic o_fault_line_out,
  output logic o_fault_line_oe,
  output logic [2:0] o_high_side_cmd,
  output logic [2:0] o_low_side_cmd,
  output logic o_fault_seen,
  output logic o_ready
);
  // =========================================================
  // fault line synchroniser and fall detect
  // =========================================================
  logic fl_meta_ff;
  logic fl_sync_ff;
  logic fl_prev_ff;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      fl_meta_ff <= 1'b1;
      fl_sync_ff <= 1'b1;
      fl_prev_ff <= 1'b1;
    end else begin
      fl_meta_ff <= i_fault_line_in;
      fl_sync_ff <= fl_meta_ff;
      fl_prev_ff <= fl_sync_ff;
    end
  end
  logic ext_low;
  // a low we did not cause is a device fault (own pulls excluded)
  assign ext_low = !fl_sync_ff && !o_fault_line_oe;

  // =========================================================
  // state machine
  // =========================================================
  igp_state_t state_ff;
  logic [CNT_W-1:0] pulse_cnt_ff;
  // 64 bits, although the two-second default of 400000000 cycles fits in CNT_W
  logic [63:0] wait_cnt_ff;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state_ff <= IGP_ST_STOP;
    end else begin
      case (state_ff)
        IGP_ST_RUN: begin
          if (ext_low) state_ff <= IGP_ST_WAIT;
          else if (i_shutdown_req) state_ff <= IGP_ST_SHDN;
          else if (!i_run) state_ff <= IGP_ST_STOP;
        end
        IGP_ST_STOP: begin
          if (ext_low) state_ff <= IGP_ST_WAIT;
          else if (i_shutdown_req) state_ff <= IGP_ST_SHDN;
          else if (i_run) state_ff <= IGP_ST_RUN;
        end
        IGP_ST_SHDN: begin
          // the low level stands at least the minimum pulse width
          if (pulse_cnt_ff >= CNT_W'(SHUTDOWN_PULSE_CYC) &&
              !i_shutdown_req) begin
            state_ff <= IGP_ST_WAIT;
          end
        end
        IGP_ST_WAIT: begin
          if (wait_cnt_ff >= 64'(RESTART_CYC) && fl_sync_ff)
            state_ff <= IGP_ST_STOP;
        end
        default: state_ff <= IGP_ST_STOP;
      endcase
    end
  end

  // shutdown pulse width counter
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || state_ff != IGP_ST_SHDN) pulse_cnt_ff <= '0;
    else if (pulse_cnt_ff < CNT_W'(SHUTDOWN_PULSE_CYC))
      pulse_cnt_ff <= pulse_cnt_ff + CNT_W'(1);
  end

  // restart wait: restarts while the line is still low, so the two
  // seconds count from the end of the fault
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || state_ff != IGP_ST_WAIT || !fl_sync_ff)
      wait_cnt_ff <= '0;
    else if (wait_cnt_ff < 64'(RESTART_CYC))
      wait_cnt_ff <= wait_cnt_ff + 64'd1;
  end

  // =========================================================
  // fault line drive: high time after a shutdown is kept by WAIT
  // =========================================================
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_fault_line_oe <= 1'b0;
      o_fault_line_out <= 1'b0;
    end else begin
      o_fault_line_out <= 1'b0;
      o_fault_line_oe <= (state_ff == IGP_ST_SHDN);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_fault_seen <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      o_fault_seen <= (state_ff == IGP_ST_WAIT);
      o_ready <= (state_ff == IGP_ST_STOP) || (state_ff == IGP_ST_RUN);
    end
  end

  // =========================================================
  // commands through the dead-time shaper
  // =========================================================
  igp_phase_if pif ();
  logic run_en;
  // enable drops combinationally on a fault so commands fall next edge
  assign run_en = (state_ff == IGP_ST_RUN) && !ext_low;
  assign pif.want_high = i_want_high;
  assign pif.want_low = i_want_low;
  assign pif.enable = run_en;

  igp_dead_time #(.DEAD_CYC(DEAD_CYC)) igp_dead_time_inst (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .pif(pif)
  );

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !run_en) begin
      o_high_side_cmd <= 3'h0;
      o_low_side_cmd <= 3'h0;
    end else begin
      o_high_side_cmd <= pif.high_side_cmd;
      o_low_side_cmd <= pif.low_side_cmd;
    end
  end

  // =========================================================
  // checks
  // =========================================================
  cmds_drop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    fl_prev_ff && !fl_sync_ff && !o_fault_line_oe |-> ##[1:3]
    (o_high_side_cmd == 3'h0 && o_low_side_cmd == 3'h0))
    else $error("commands not dropped after fault");
  no_overlap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_high_side_cmd & o_low_side_cmd) == 3'h0)
    else $error("overlapping phase commands");
  no_run_wait_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state_ff == IGP_ST_WAIT |=> !(state_ff == IGP_ST_RUN))
    else $error("ran straight from wait");
  restart_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $past(state_ff) == IGP_ST_WAIT && state_ff == IGP_ST_STOP |->
    $past(wait_cnt_ff) >= 64'(RESTART_CYC))
    else $error("restart before wait elapsed");
  shdn_width_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $fell(o_fault_line_oe) |-> $past(pulse_cnt_ff, 2) >=
    CNT_W'(SHUTDOWN_PULSE_CYC))
    else $error("shutdown pulse too short");
  shdn_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_fault_line_oe |->
    (o_high_side_cmd | o_low_side_cmd) == 3'h0)
    else $error("commands during shutdown");
  hold_low_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $rose(o_fault_line_oe) |=> o_fault_line_oe [*8])
    else $error("shutdown low released early");
  drive_low_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_fault_line_oe |-> !o_fault_line_out)
    else $error("open drain driven high");
  fault_quiet_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_fault_seen |-> (o_high_side_cmd | o_low_side_cmd) == 3'h0)
    else $error("commands during fault wait");

  run_c: cover property (@(posedge i_mclk) state_ff == IGP_ST_RUN);
  fault_c: cover property (@(posedge i_mclk)
    state_ff == IGP_ST_RUN ##1 state_ff == IGP_ST_WAIT);
  shdn_c: cover property (@(posedge i_mclk) $fell(o_fault_line_oe));
  restart_c: cover property (@(posedge i_mclk)
    state_ff == IGP_ST_WAIT ##1 state_ff == IGP_ST_STOP);
  stop_c: cover property (@(posedge i_mclk)
    state_ff == IGP_ST_RUN ##1 state_ff == IGP_ST_STOP);
endmodule : igp_host_ctrl

// ==== shared/igp_pkg.sv ====
/*
  Constants and types for the host-side controller of the inverter gate
  driver protection logic.
  Assumes a 200 MHz system clock.
*/
package igp_pkg;
  // =========================================================
  // clock and timing
  // =========================================================
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FAULT_HOLD_NS = 26000;
  localparam int SHUTDOWN_PULSE_NS = 3000;
  localparam int RESTART_WAIT_MS = 2000;
  localparam int HOLD_WITHIN_NS = 15000;
  localparam int SHUTDOWN_PULSE_CYC = (SHUTDOWN_PULSE_NS * 1000 +
    CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint RESTART_WAIT_CYC =
    (64'(RESTART_WAIT_MS) * 64'd1000000000 + CLK_PERIOD_PS - 1) /
    CLK_PERIOD_PS;
  localparam int DEAD_TIME_NS = 1000;
  localparam int DEAD_TIME_CYC = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int NUM_PHASES = 3;
  localparam int CNT_W = 32;

  typedef enum logic [3:0] {
    IGP_ST_RUN = 4'h1,
    IGP_ST_STOP = 4'h2,
    IGP_ST_WAIT = 4'h4,
    IGP_ST_SHDN = 4'h8
  } igp_state_t;
endpackage : igp_pkg

// ==== shared/igp_phase_if.sv ====
/*
  Per-phase command bundle between the controller and its phase shaper.
  Assumes both ends on the same clock.
*/
`timescale 1ns/100ps
interface igp_phase_if;
  logic [2:0] want_high;
  logic [2:0] want_low;
  logic enable;
  logic [2:0] high_side_cmd;
  logic [2:0] low_side_cmd;
  modport ctrl (output want_high, output want_low, output enable,
    input high_side_cmd, input low_side_cmd);
  modport shaper (input want_high, input want_low, input enable,
    output high_side_cmd, output low_side_cmd);
endinterface : igp_phase_if

// ==== hdl/igp_dead_time.sv ====
/*
  Dead-time shaper: turns wanted phase levels into high_side_cmd and
  low_side_cmd with a gap when one side is wanted while the other is on, never both high.
  Assumes enable low forces all commands low at once.
*/
`timescale 1ns/100ps
module igp_dead_time
  import igp_pkg::*;
#(
  parameter int DEAD_CYC = DEAD_TIME_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  igp_phase_if.shaper pif
);
  // =========================================================
  // per-phase gap counter
  // =========================================================
  for (genvar p = 0; p < NUM_PHASES; p++) begin : g_ph
    logic [15:0] gap_ff;
    logic hi_ff;
    logic lo_ff;
    always_ff @(posedge i_mclk) begin
      if (!i_rst_b || !pif.enable) begin
        hi_ff <= 1'b0;
        lo_ff <= 1'b0;
        gap_ff <= 16'(DEAD_CYC);
      end else if (pif.want_high[p] && pif.want_low[p]) begin
        // an overlap request is never honoured
        hi_ff <= 1'b0;
        lo_ff <= 1'b0;
        gap_ff <= 16'(DEAD_CYC);
      end else if ((pif.want_high[p] && lo_ff) ||
                   (pif.want_low[p] && hi_ff)) begin
        hi_ff <= 1'b0;
        lo_ff <= 1'b0;
        gap_ff <= 16'(DEAD_CYC);
      end else if (gap_ff != 16'h0000) begin
        gap_ff <= gap_ff - 16'h0001;
        hi_ff <= hi_ff & pif.want_high[p];
        lo_ff <= lo_ff & pif.want_low[p];
      end else begin
        hi_ff <= pif.want_high[p];
        lo_ff <= pif.want_low[p];
      end
    end
    assign pif.high_side_cmd[p] = hi_ff;
    assign pif.low_side_cmd[p] = lo_ff;

    never_both_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      !(hi_ff && lo_ff)) else $error("both commands high");
  end
endmodule : igp_dead_time

// ==== testbench/igp_dev_model.sv ====
/*
  Behavioural model of the gate-driver device that the controller drives.
  Assumes one shared clock and a wired fault line with a pull-up.
*/
`timescale 1ns/100ps
module igp_dev_model #(
  parameter int BLANK_CYC = 74,
  parameter int DELAY_CYC = 60,
  parameter int HOLD_CYC = 5200,
  parameter int UVF_CYC = 600,
  parameter int OVF_CYC = 160,
  parameter int SDF_CYC = 60
) (
  input wire logic i_mclk,
  input wire logic [2:0] i_hcmd,
  input wire logic [2:0] i_lcmd,
  input wire logic i_line,
  input wire logic i_ocp,
  input wire logic i_uv,
  input wire logic i_boot,
  output logic o_pull,
  output logic [2:0] o_high_gate,
  output logic [2:0] o_low_gate
);
  int ocp_cnt = 0;
  int trip_cnt = 0;
  int uv_cnt = 0;
  int ov_cnt = 0;
  int sd_cnt = 0;
  int bt_cnt = 0;
  logic trip = 1'b0;
  logic bt_arm = 1'b1;
  logic hcmd0_q = 1'b0;
  logic [2:0] off;
  // ==========================================================
  // protections
  // ==========================================================
  always @(posedge i_mclk) begin
    ocp_cnt <= i_ocp ? ocp_cnt + 1 : 0;
    if (ocp_cnt == BLANK_CYC) trip <= 1'b1;
    trip_cnt <= trip ? trip_cnt + 1 : 0;
    if (trip_cnt == DELAY_CYC + HOLD_CYC) trip <= 1'b0;
    uv_cnt <= i_uv ? uv_cnt + 1 : 0;
    ov_cnt <= |(i_hcmd & i_lcmd) ? ov_cnt + 1 : 0;
    sd_cnt <= i_line ? 0 : sd_cnt + 1;
  end
  // boot lockout modelled on the first phase only; it never pulls the line
  always @(posedge i_mclk) begin
    bt_cnt <= i_boot ? bt_cnt + 1 : 0;
    hcmd0_q <= i_hcmd[0];
    if (bt_cnt >= UVF_CYC) bt_arm <= 1'b0;
    else if (i_hcmd[0] && !hcmd0_q) bt_arm <= 1'b1;
  end
  assign o_pull = (trip && trip_cnt >= DELAY_CYC) || uv_cnt >= UVF_CYC ||
    ov_cnt >= OVF_CYC;
  // ==========================================================
  // gates
  // ==========================================================
  assign off[0] = !i_line || uv_cnt >= UVF_CYC;
  assign off[2] = off[0];
  assign off[1] = sd_cnt >= SDF_CYC || uv_cnt >= UVF_CYC;
  assign o_high_gate = ~off & i_hcmd & ~i_lcmd &
    {2'b11, bt_arm};
  assign o_low_gate = ~off & i_lcmd & ~i_hcmd;
endmodule : igp_dev_model

// ==== testbench/igp_host_ctrl_tb_top.sv ====
/*
  Self-checking bench for the host controller against the device model.
  Assumes the restart wait is shortened to 2000 cycles.
*/
`timescale 1ns/100ps
module igp_host_ctrl_tb_top;
  localparam int RST_CYC = 2000;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] want_h = 3'h0;
  logic [2:0] want_l = 3'h0;
  logic run = 1'b0;
  logic shdn = 1'b0;
  logic ocp = 1'b0;
  logic uv = 1'b0;
  logic boot = 1'b0;
  logic out, oe, seen, rdy, pull;
  logic [2:0] hcmd, lcmd, hg, lg;
  // open-drain wire: low when any party pulls it
  wire line = !((oe && !out) || pull);
  int n_mismatch = 0;
  int total_checks = 0;

  igp_host_ctrl #(.RESTART_CYC(RST_CYC), .DEAD_CYC(4)) igp_host_ctrl_inst (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_want_high(want_h),
    .i_want_low(want_l), .i_run(run), .i_shutdown_req(shdn),
    .i_fault_line_in(line), .o_fault_line_out(out), .o_fault_line_oe(oe),
    .o_high_side_cmd(hcmd), .o_low_side_cmd(lcmd), .o_fault_seen(seen),
    .o_ready(rdy));
  igp_dev_model igp_dev_model_inst (.i_mclk(i_mclk), .i_hcmd(hcmd),
    .i_lcmd(lcmd), .i_line(line), .i_ocp(ocp), .i_uv(uv), .o_pull(pull),
    .i_boot(boot), .o_high_gate(hg), .o_low_gate(lg));

  initial forever #2.5 i_mclk = ~i_mclk;
  // ==========================================================
  // helpers
  // ==========================================================
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic restart;
    for (int i = 0; i < 6000 && !line; i++) tick(1);
    tick(RST_CYC - 100);
    chk(rdy, 1'b0);
    for (int i = 0; i < 300 && !rdy; i++) tick(1);
    chk(rdy, 1'b1);
    tick(20);
    chk({2'h0, hg, lg}, {2'h0, want_h, want_l});
  endtask : restart
  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_normal;
    want_h = 3'h5;
    want_l = 3'h2;
    run = 1'b1;
    tick(20);
    chk({2'h0, hcmd, lcmd}, 8'h2A);
    chk({2'h0, hg, lg}, 8'h2A);
    want_h = 3'h2;
    want_l = 3'h5;
    tick(20);
    chk({2'h0, hg, lg}, 8'h15);
    // the middle phase asks for both sides at once and must get neither
    want_h = 3'h3;
    want_l = 3'h6;
    tick(20);
    chk({2'h0, hcmd, lcmd}, 8'h0C);
    run = 1'b0;
    tick(5);
    chk({1'h0, rdy, hcmd, lcmd}, 8'h40);
    run = 1'b1;
  endtask : t_normal
  task automatic t_boot;
    want_h = 3'h3;
    want_l = 3'h4;
    tick(20);
    chk({line, hg, lg}, 8'h5C);
    boot = 1'b1;
    tick(700);
    chk({line, hg, lg}, 8'h54);
    boot = 1'b0;
    tick(20);
    chk({line, hg, lg}, 8'h54);
    want_h = 3'h2;
    want_l = 3'h5;
    tick(20);
    want_h = 3'h3;
    want_l = 3'h4;
    tick(20);
    chk({line, hg, lg}, 8'h5C);
  endtask : t_boot
  task automatic t_short;
    ocp = 1'b1;
    tick(50);
    ocp = 1'b0;
    uv = 1'b1;
    tick(500);
    uv = 1'b0;
    tick(50);
    chk({seen, oe, line}, 8'h01);
  endtask : t_short
  task automatic t_ocp;
    ocp = 1'b1;
    tick(100);
    ocp = 1'b0;
    for (int i = 0; i < 300 && line; i++) tick(1);
    tick(10);
    chk({2'h0, hcmd, lcmd}, 8'h00);
    chk({seen, line}, 8'h02);
    tick(4000);
    chk({line, rdy}, 8'h00);
    restart();
  endtask : t_ocp
  task automatic t_shdn;
    shdn = 1'b1;
    tick(3);
    chk({oe, out}, 8'h02);
    tick(5);
    chk({2'h0, hg, lg}, 8'h00);
    tick(580);
    chk(oe, 1'b1);
    shdn = 1'b0;
    restart();
  endtask : t_shdn
  task automatic t_uv;
    uv = 1'b1;
    tick(700);
    chk({seen, line, hg, lg}, 8'h80);
    uv = 1'b0;
    restart();
  endtask : t_uv

  always @(negedge i_mclk) begin
    if (i_rst_b && (hcmd & lcmd) !== 3'h0) begin
      chk({5'h0, hcmd & lcmd}, 8'h00);
    end
  end
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    tick(20);
    i_rst_b = 1'b1;
    tick(5);
    t_normal();
    t_boot();
    t_short();
    t_ocp();
    t_shdn();
    t_uv();
    end_sim();
  end
endmodule : igp_host_ctrl_tb_top
